// ==== logic/ecia_cfg.svh ====
// constants of the interrupt aggregator: offsets, reset values, counts
`ifndef ECIA_CFG_SVH
`define ECIA_CFG_SVH
`define ECIA_NGRP 16
`define ECIA_NSRC 31
// per-group register block: source, enable, result, stride of 14h
`define ECIA_GRP_STRIDE 10'h014
`define ECIA_SRC_OFS 10'h000
`define ECIA_EN_OFS 10'h004
`define ECIA_RES_OFS 10'h008
// block select and event registers
`define ECIA_BLKSEL_OFS 10'h200
`define ECIA_EVST_OFS 10'h210
`define ECIA_EVCLR_OFS 10'h214
`define ECIA_EVEN_OFS 10'h218
// reset values
`define ECIA_SRC_RST 31'h00000000
`define ECIA_EN_RST 31'h00000000
`define ECIA_BLKSEL_RST 16'hFFFF
`define ECIA_EV_RST 16'h0000
// sources able to wake the system, same mask for every group
`define ECIA_WAKE_MASK 31'h7FFFFFFF
`endif

// ==== logic/ecia_pkg.sv ====
// types of the interrupt aggregator
package ecia_pkg;
    typedef logic [15:0][30:0] ecia_grp_t;

    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ecia_wb_req_s;

    // wishbone answer to the master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ecia_wb_rsp_s;

    // complete state of the aggregator
    typedef struct packed {
        ecia_grp_t sync1;
        ecia_grp_t sync2;
        ecia_grp_t src;
        ecia_grp_t en;
        logic [15:0] blksel;
        logic [15:0] req_prev;
        logic [15:0] evst;
        logic [15:0] even;
        logic ev_irq;
        logic ack;
        logic [31:0] rdat;
    } ecia_state_s;
endpackage : ecia_pkg

// ==== logic/ecia_top.sv ====
// interrupt aggregator: 16 groups of 31 level sources on wishbone
`timescale 1ns/10ps
`default_nettype none
`include "ecia_cfg.svh"

module ecia_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire ecia_pkg::ecia_grp_t src_i,
    input wire ecia_pkg::ecia_wb_req_s wb_req_i,
    output ecia_pkg::ecia_wb_rsp_s wb_rsp_o,
    output logic [15:0] irq_req_o,
    output logic wake_o,
    output logic ev_irq_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ecia_pkg::ecia_state_s st_q;
    ecia_pkg::ecia_state_s st_d;
    ecia_pkg::ecia_grp_t res;
    logic [15:0] grp_wake;
    logic wb_go;
    logic [9:0] ofs;

    // ------------------------------------------------------------
    // clockless aggregation per group
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `ECIA_NGRP; g = g + 1) begin : g_grp
            // result of one group
            assign res[g] = st_q.src[g] & st_q.en[g];
            // only maskable requests pass here, gated by the block select
            assign irq_req_o[g] = (|res[g]) & st_q.blksel[g];
            // wake term of one group
            assign grp_wake[g] = |(res[g] & `ECIA_WAKE_MASK);
        end
    endgenerate

    // wake is an OR of latched results, so new sources reach it only through clocked flops
    assign wake_o = |grp_wake;

    // bus answer comes from flops
    assign wb_rsp_o.ack = st_q.ack;
    assign wb_rsp_o.dat = st_q.rdat;
    assign ev_irq_o = st_q.ev_irq;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign wb_go = wb_req_i.cyc & wb_req_i.stb & ~st_q.ack;
    assign ofs = wb_req_i.adr[9:0];

    // byte-lane merge of write data into a stored value
    function automatic logic [31:0] ecia_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : ecia_merge

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [9:0] base;
        logic [31:0] wmask;
        logic [31:0] tmp;
        logic [15:0] clr;
        logic [15:0] evset;
        logic [15:0] grp_req;
        base = 10'h000;
        wmask = 32'h00000000;
        tmp = 32'h00000000;
        clr = 16'h0000;
        evset = 16'h0000;
        grp_req = 16'h0000;
        st_d = st_q;
        // two-flop synchroniser for all source pins
        st_d.sync1 = src_i;
        st_d.sync2 = st_q.sync1;
        st_d.ack = wb_go;
        st_d.rdat = 32'h00000000;
        wmask = ecia_merge(32'h00000000, 32'hFFFFFFFF, wb_req_i.sel);
        // register accesses, unmapped reads return zero
        for (int i = 0; i < `ECIA_NGRP; i++) begin
            base = 10'(i * 20);
            // sticky set while input high
            st_d.src[i] = st_q.src[i] | st_q.sync2[i];
            if (wb_go && ofs == base + `ECIA_SRC_OFS) begin
                st_d.rdat = {1'b0, st_q.src[i]};
                if (wb_req_i.we) begin
                    // write-one clears, a live input keeps it set
                    st_d.src[i] = (st_q.src[i]
                        & ~(wb_req_i.dat[30:0] & wmask[30:0]))
                        | st_q.sync2[i];
                end
            end
            if (wb_go && ofs == base + `ECIA_EN_OFS) begin
                st_d.rdat = {1'b0, st_q.en[i]};
                if (wb_req_i.we) begin
                    tmp = ecia_merge({1'b0, st_q.en[i]}, wb_req_i.dat,
                        wb_req_i.sel);
                    st_d.en[i] = tmp[30:0];
                end
            end
            if (wb_go && ofs == base + `ECIA_RES_OFS) begin
                st_d.rdat = {1'b0, res[i]};
            end
        end
        if (wb_go && ofs == `ECIA_BLKSEL_OFS) begin
            st_d.rdat = {16'h0000, st_q.blksel};
            if (wb_req_i.we) begin
                tmp = ecia_merge({16'h0000, st_q.blksel}, wb_req_i.dat,
                    wb_req_i.sel);
                st_d.blksel = tmp[15:0];
            end
        end
        if (wb_go && ofs == `ECIA_EVST_OFS) begin
            st_d.rdat = {16'h0000, st_q.evst};
        end
        if (wb_go && ofs == `ECIA_EVCLR_OFS && wb_req_i.we) begin
            clr = wb_req_i.dat[15:0] & wmask[15:0];
        end
        if (wb_go && ofs == `ECIA_EVEN_OFS) begin
            st_d.rdat = {16'h0000, st_q.even};
            if (wb_req_i.we) begin
                tmp = ecia_merge({16'h0000, st_q.even}, wb_req_i.dat,
                    wb_req_i.sel);
                st_d.even = tmp[15:0];
            end
        end
        // events: rising group request, set wins over clear
        grp_req = irq_req_o;
        evset = grp_req & ~st_q.req_prev;
        st_d.req_prev = grp_req;
        st_d.evst = (st_q.evst & ~clr) | evset;
        st_d.ev_irq = |(st_d.evst & st_d.even);
        // watchdog reset
        if (rst_i) begin
            for (int i = 0; i < `ECIA_NGRP; i++) begin
                st_d.src[i] = `ECIA_SRC_RST;
                st_d.en[i] = `ECIA_EN_RST;
                st_d.sync1[i] = `ECIA_SRC_RST;
                st_d.sync2[i] = `ECIA_SRC_RST;
            end
            st_d.blksel = `ECIA_BLKSEL_RST;
            st_d.req_prev = `ECIA_EV_RST;
            st_d.evst = `ECIA_EV_RST;
            st_d.even = `ECIA_EV_RST;
            st_d.ev_irq = 1'b0;
            st_d.ack = 1'b0;
            st_d.rdat = 32'h00000000;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reset empties sources and enables and selects every group
    property p_rst_clear;
        @(posedge clk_i) rst_i |=> (st_q.src == '0 && st_q.en == '0
            && st_q.blksel == 16'hFFFF && !wake_o && irq_req_o == 16'h0000);
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("reset did not clear aggregator state");

    // a source held high for three cycles is latched
    property p_src_set;
        @(posedge clk_i) disable iff (rst_i)
        src_i[0][0] [*3] |=> st_q.src[0][0];
    endproperty
    a_src_set: assert property (p_src_set)
        else $error("held source was not latched");

    // a latched source with its input still high survives a clear
    property p_src_hold;
        @(posedge clk_i) disable iff (rst_i)
        st_q.src[5][5] && st_q.sync2[5][5] |=> st_q.src[5][5];
    endproperty
    a_src_hold: assert property (p_src_hold)
        else $error("live source was cleared");

    // a source never sets without a synchronised input
    property p_src_cause;
        @(posedge clk_i) disable iff (rst_i)
        $rose(st_q.src[7][30]) |-> $past(st_q.sync2[7][30]);
    endproperty
    a_src_cause: assert property (p_src_cause)
        else $error("source set without input");

    // result reads return source and enable combined
    property p_res_read;
        @(posedge clk_i) disable iff (rst_i)
        wb_go && !wb_req_i.we && ofs == 10'h01C
            |=> wb_rsp_o.dat == {1'b0, $past(st_q.src[1] & st_q.en[1])};
    endproperty
    a_res_read: assert property (p_res_read)
        else $error("result read mismatch");

    // a deselected group never requests
    property p_blksel;
        @(posedge clk_i) disable iff (rst_i)
        !st_q.blksel[1] |-> !irq_req_o[1];
    endproperty
    a_blksel: assert property (p_blksel)
        else $error("deselected group requested");

    // a request needs some enabled pending source
    property p_req_cause;
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o[15] |-> (st_q.src[15] & st_q.en[15]) != 31'h00000000;
    endproperty
    a_req_cause: assert property (p_req_cause)
        else $error("request without enabled source");

    // nothing enabled means no wake
    property p_wake;
        @(posedge clk_i) disable iff (rst_i)
        st_q.en == '0 |-> !wake_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without enabled source");

    // bus answers in one cycle, single ack pulse
    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        wb_go |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack timing wrong");

    // enabled event raises interrupt one cycle later
    property p_ev_irq;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.evst & st_q.even) != 16'h0000 |=> ev_irq_o
            || $past(wb_go && wb_req_i.we && (ofs == `ECIA_EVCLR_OFS
            || ofs == `ECIA_EVEN_OFS));
    endproperty
    a_ev_irq: assert property (p_ev_irq)
        else $error("event interrupt missing");

    // a write-one clear with the input low empties the bit
    property p_src_clear;
        @(posedge clk_i) disable iff (rst_i)
        wb_go && wb_req_i.we && ofs == 10'h064 && wb_req_i.sel[0]
            && wb_req_i.dat[0] && !st_q.sync2[5][0] |=> !st_q.src[5][0];
    endproperty
    a_src_clear: assert property (p_src_clear)
        else $error("cleared source stayed set");

    // a full-word enable write lands in the enable register
    property p_en_write;
        @(posedge clk_i) disable iff (rst_i)
        wb_go && wb_req_i.we && ofs == 10'h004 && wb_req_i.sel == 4'hF
            |=> st_q.en[0] == $past(wb_req_i.dat[30:0]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable write lost");

    // a source read returns the latched bits
    property p_src_read;
        @(posedge clk_i) disable iff (rst_i)
        wb_go && !wb_req_i.we && ofs == 10'h028
            |=> wb_rsp_o.dat == {1'b0, $past(st_q.src[2])};
    endproperty
    a_src_read: assert property (p_src_read)
        else $error("source read mismatch");

    // a full-word select write lands in the select register
    property p_blksel_write;
        @(posedge clk_i) disable iff (rst_i)
        wb_go && wb_req_i.we && ofs == `ECIA_BLKSEL_OFS
            && wb_req_i.sel == 4'hF
            |=> st_q.blksel == $past(wb_req_i.dat[15:0]);
    endproperty
    a_blksel_write: assert property (p_blksel_write)
        else $error("select write lost");

    // an enabled pending source always asks for wake
    property p_wake_src;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.src[4] & st_q.en[4]) != 31'h00000000 |-> wake_o;
    endproperty
    a_wake_src: assert property (p_wake_src)
        else $error("enabled source gave no wake");

    // a selected group with an enabled source requests
    property p_irq_gate;
        @(posedge clk_i) disable iff (rst_i)
        st_q.blksel[6] && (st_q.src[6] & st_q.en[6]) != 31'h00000000
            |-> irq_req_o[6];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("selected group did not request");

    // unmapped reads answer zero
    property p_unmapped;
        @(posedge clk_i) disable iff (rst_i)
        wb_go && !wb_req_i.we && ofs == 10'h3FC
            |=> wb_rsp_o.dat == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    // a rising group request sets its event bit
    property p_evst_set;
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o[0] && !st_q.req_prev[0] |=> st_q.evst[0];
    endproperty
    a_evst_set: assert property (p_evst_set)
        else $error("event bit not set");

    // no request, no acknowledge
    property p_ack_idle;
        @(posedge clk_i) disable iff (rst_i)
        !(wb_req_i.cyc && wb_req_i.stb) |=> !wb_rsp_o.ack;
    endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("ack without request");

    // read data is zero outside the acknowledge cycle
    property p_dat_idle;
        @(posedge clk_i) disable iff (rst_i)
        !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h00000000;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");

endmodule : ecia_top
`default_nettype wire

// ==== testbench/ec_interrupt_aggregator_test.sv ====
// self-checking bench of the interrupt aggregator
`timescale 1ns/10ps
`default_nettype none
module ec_interrupt_aggregator_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ecia_pkg::ecia_grp_t src_i = '0;
    ecia_pkg::ecia_wb_req_s wb_req = '0;
    ecia_pkg::ecia_wb_rsp_s wb_rsp;
    logic [15:0] irq_req;
    logic [15:0] exv = '0;
    logic wake;
    logic wk;
    logic ev_irq;
    logic [31:0] cpu_irq;
    logic [31:0] rnd = 32'h0000000B;
    logic [31:0] q;
    logic [31:0] e;
    logic [31:0] s;
    int n_mismatch = 0;
    int n_checks = 0;

    // clock
    always #5 clk_i = ~clk_i;

    ecia_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .src_i(src_i),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .irq_req_o(irq_req),
        .wake_o(wake), .ev_irq_o(ev_irq));
    ecia_cpu_model u_cpu (.irq_req_i(irq_req), .wake_i(wake),
        .irq_line_o(cpu_irq), .wake_o(wk));

    // next pseudo-random word
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // expected group request
    function automatic logic ex_irq(input logic [30:0] sv,
        input logic [30:0] ev, input logic sl);
        return (|(sv & ev)) & sl;
    endfunction : ex_irq

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // one counted compare
    task automatic chk(input string nm, input logic [31:0] ex,
        input logic [31:0] gt);
        n_checks++;
        if (ex !== gt) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, ex, gt);
        end
    endtask : chk

    // classic wishbone cycle, bounded wait for ack
    task automatic wb(input logic we, input logic [9:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we,
            adr: {22'h000000, a}, sel: 4'hF, dat: d};
        @(posedge clk_i);
        while (wb_rsp.ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                chk("ack", 32'h1, 32'h0);
                wrap_up();
            end
            @(posedge clk_i);
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clk_i);
    endtask : wb

    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 10'h200, '0, q);
        chk("blksel", 32'h0000FFFF, q);
        wb(1'b0, 10'h004, '0, q);
        chk("enable", 32'h0, q);
        chk("irq", 32'h0, cpu_irq);
        for (int g = 0; g < 16; g++) begin
            rnd = xs(rnd);
            e = rnd;
            rnd = xs(rnd);
            s = (g == 3) ? 32'h0 : rnd;
            e = (g == 5) ? 32'hFFFFFFFF : e;
            wb(1'b1, 10'(g * 20) + 10'h004, e, q);
            src_i[g] <= s[30:0];
            repeat (4) @(posedge clk_i);
            exv[g] = ex_irq(s[30:0], e[30:0], 1'b1);
            wb(1'b0, 10'(g * 20), '0, q);
            chk("source", {1'b0, s[30:0]}, q);
            wb(1'b0, 10'(g * 20) + 10'h008, '0, q);
            chk("result", {1'b0, s[30:0] & e[30:0]}, q);
            chk("irq", {8'h00, exv, 8'h00}, cpu_irq);
            chk("wake", {31'h0, |exv}, {31'h0, wk});
        end
        // event flags: masked, raised, cleared, read-only status
        wb(1'b0, 10'h210, '0, q);
        chk("evst", {16'h0, exv}, q);
        chk("ev_irq", 32'h0, {31'h0, ev_irq});
        wb(1'b1, 10'h218, 32'h0000FFFF, q);
        repeat (2) @(posedge clk_i);
        chk("ev_irq", {31'h0, |exv}, {31'h0, ev_irq});
        wb(1'b1, 10'h214, 32'h0000FFFF, q);
        wb(1'b1, 10'h210, 32'h0000FFFF, q);
        repeat (2) @(posedge clk_i);
        wb(1'b0, 10'h210, '0, q);
        chk("evst", 32'h0, q);
        chk("ev_irq", 32'h0, {31'h0, ev_irq});
        wb(1'b0, 10'h3FC, '0, q);
        chk("unmapped", 32'h0, q);
        // block select gates each group
        wb(1'b1, 10'h200, 32'h00005555, q);
        chk("irq", {8'h00, exv & 16'h5555, 8'h00}, cpu_irq);
        wb(1'b1, 10'h200, 32'h0000FFFF, q);
        // sticky source, clear refused while input high
        src_i[5] <= 31'h7FFFFFFF;
        repeat (4) @(posedge clk_i);
        wb(1'b1, 10'(100), 32'hFFFFFFFF, q);
        wb(1'b0, 10'(100), '0, q);
        chk("set wins", 32'h7FFFFFFF, q);
        src_i[5] <= '0;
        repeat (4) @(posedge clk_i);
        wb(1'b0, 10'(100), '0, q);
        chk("sticky", 32'h7FFFFFFF, q);
        wb(1'b1, 10'(100), 32'h0000FFFF, q);
        wb(1'b0, 10'(100), '0, q);
        chk("w1c", 32'h7FFF0000, q);
        // mid-run watchdog reset empties live state
        wb(1'b1, 10'h200, 32'h00000000, q);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 10'(104), '0, q);
        chk("enable", 32'h0, q);
        wb(1'b0, 10'(100), '0, q);
        chk("source", 32'h0, q);
        wb(1'b0, 10'h200, '0, q);
        chk("blksel", 32'h0000FFFF, q);
        chk("irq", 32'h0, cpu_irq);
        chk("wake", 32'h0, {31'h0, wk});
        chk("ev_irq", 32'h0, {31'h0, ev_irq});
        wrap_up();
    end
endmodule : ec_interrupt_aggregator_test
`default_nettype wire

// ==== testbench/ecia_cpu_model.sv ====
// processor interrupt inputs and power manager beside the aggregator
`timescale 1ns/10ps
`default_nettype none
module ecia_cpu_model (
    input wire logic [15:0] irq_req_i,
    input wire logic wake_i,
    output logic [31:0] irq_line_o,
    output logic wake_o
);
    // group g lands on input 8+g, exception inputs never fed
    assign irq_line_o = {8'h00, irq_req_i, 8'h00};
    // wake level taken without any clock
    assign wake_o = wake_i;
endmodule : ecia_cpu_model
`default_nettype wire
